// *** logic/sfe_pkg.sv ***
package sfe_pkg;

   // -------------------------------------------------------------
   // widths and counts
   // -------------------------------------------------------------
   localparam int unsigned SFE_BYTE_W     = 8;          // one serial byte
   localparam int unsigned SFE_RX_W       = 9;          // byte plus opcode marker
   localparam int unsigned SFE_FIFO_DEPTH = 4;          // receive buffer words
   localparam int unsigned SFE_CNT_W      = 3;          // bit position counter
   localparam int unsigned SFE_PAGE_W     = 9;          // data byte counter width
   localparam int unsigned SFE_HDR_W      = 3;          // header byte counter width
   localparam int unsigned SFE_CLK_PERIOD_NS = 8;       // system clock period

   // -------------------------------------------------------------
   // fixed values
   // -------------------------------------------------------------
   localparam logic [SFE_CNT_W-1:0]  SFE_BIT_ZERO   = 3'h0;   // first bit of a byte
   localparam logic [SFE_CNT_W-1:0]  SFE_LAST_BIT   = 3'h7;   // eighth bit of a byte
   localparam logic [SFE_CNT_W-1:0]  SFE_SINGLE_REM = 3'h7;   // falls left after a single-lane load
   localparam logic [SFE_CNT_W-1:0]  SFE_DUAL_REM   = 3'h3;   // falls left after a dual-lane load
   localparam logic [SFE_PAGE_W-1:0] SFE_PAGE_BYTES = 9'h100; // one page of data bytes
   localparam logic [SFE_HDR_W-1:0]  SFE_HDR_BYTES  = 3'h4;   // opcode plus three address bytes
   localparam logic                  SFE_SEL_RST    = 1'b0;   // select history at reset
   localparam logic                  SFE_SCK_RST    = 1'b0;   // clock history at reset

   // -------------------------------------------------------------
   // state types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      SFE_ST_STANDBY,
      SFE_ST_SELECTED,
      SFE_ST_FINISHING
   } sfe_frame_t;

   typedef enum logic [1:0] {
      SFE_OUT_IDLE,
      SFE_OUT_SINGLE,
      SFE_OUT_DUAL
   } sfe_out_t;

endpackage

// *** logic/sfe_stream_if.sv ***
`timescale 1ns/1ps
// -------------------------------------------------------------
// valid/ready word stream between internal modules
// -------------------------------------------------------------
interface sfe_stream_if #(parameter int unsigned WIDTH = 9);
   logic             valid;   // word offered
   logic             ready;   // word accepted
   logic [WIDTH-1:0] data;    // word payload

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** logic/sfe_edge.sv ***
`timescale 1ns/1ps
// -------------------------------------------------------------
// edge finder for a pin already synchronous to clk
// -------------------------------------------------------------
module sfe_edge #(
   parameter logic RESET_LEVEL = 1'b0
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic level,
   output logic      level_q,
   output logic      rise,
   output logic      fall
);

   // history of the pin, one clock old
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level_q <= RESET_LEVEL;
      end else begin
         level_q <= level;
      end
   end

   // edges are one-cycle pulses in the cycle the pin changes
   assign rise = level & ~level_q;
   assign fall = ~level & level_q;

endmodule

// *** logic/sfe_fifo.sv ***
`timescale 1ns/1ps
// -------------------------------------------------------------
// small show-ahead fifo, honest full and empty
// -------------------------------------------------------------
module sfe_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic clk,
   input  wire logic resetn,
   sfe_stream_if.snk wr,
   sfe_stream_if.src rd
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // word storage
   logic [AW-1:0]    wr_ptr;        // next slot to fill
   logic [AW-1:0]    rd_ptr;        // oldest word
   logic [AW:0]      count;         // words held
   logic             do_wr;         // write this cycle
   logic             do_rd;         // read this cycle

   assign wr.ready = (count != FULL_CNT);
   assign rd.valid = (count != '0);
   assign rd.data  = mem[rd_ptr];
   assign do_wr    = wr.valid & wr.ready;
   assign do_rd    = rd.valid & rd.ready;

   // storage has no reset; only the pointers and count define what is valid
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr.data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // fill level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (do_wr & ~do_rd) begin
         count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
         count <= count - 1'b1;
      end
   end

endmodule

// *** logic/sfe_front_end.sv ***
`timescale 1ns/1ps
// Function
// - select fall starts every operation
// - select rise ends the current operation
// - deselected: standby, serial output released
// - deselected: input pin ignored, nothing shifted
// - self-timed cycle delays standby past deselect
// - input bits sampled on serial clock rise
// - output bits change only on clock fall
// - dual read: lane0 becomes output, two bits
// - dual read: lane1 stays driven output
// - works with clock idling low or high
// - program counts up to 256 data bytes, later bytes still pass
// - pause ignores clock and input, releases outputs
module sfe_front_end
   import sfe_pkg::*;
#(
   parameter int unsigned               FIFO_DEPTH = sfe_pkg::SFE_FIFO_DEPTH,
   parameter logic [sfe_pkg::SFE_PAGE_W-1:0] PAGE_BYTES = sfe_pkg::SFE_PAGE_BYTES,
   parameter logic [sfe_pkg::SFE_HDR_W-1:0]  HDR_BYTES  = sfe_pkg::SFE_HDR_BYTES
) (
   input  wire logic                              clk,
   input  wire logic                              resetn,
   input  wire logic                              select_n,
   input  wire logic                              sck,
   input  wire logic                              pause_n,
   input  wire logic                              dual_lane0_in,
   output logic                                   dual_lane0_out,
   output logic                                   dual_lane0_oe,
   output logic                                   dual_lane1_out,
   output logic                                   dual_lane1_oe,
   output logic [sfe_pkg::SFE_BYTE_W-1:0]         rx_data,
   output logic                                   rx_first,
   output logic                                   rx_valid,
   input  wire logic                              rx_ready,
   input  wire logic [sfe_pkg::SFE_BYTE_W-1:0]    tx_data,
   input  wire logic                              tx_valid,
   output logic                                   tx_ack,
   input  wire logic                              dual_read,
   input  wire logic                              op_busy,
   output logic                                   frame_active,
   output logic                                   frame_end,
   output logic                                   standby,
   output logic                                   page_full,
   output logic                                   rx_overrun,
   output logic                                   tx_underrun
);
   import sfe_pkg::*;

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   sfe_frame_t              state;          // frame state
   sfe_out_t                out_state;      // output lane mode
   logic                    sck_q;          // clock history
   logic                    sck_rise;       // clock rise pulse
   logic                    sck_fall;       // clock fall pulse
   logic                    sel_q;          // select history
   logic                    sel_rise;       // deselect pulse
   logic                    sel_fall;       // select pulse
   logic                    live;           // selected and not paused
   logic                    in_rise;        // clock rise that may sample
   logic                    in_fall;        // clock fall that may drive
   logic [SFE_CNT_W-1:0]    bit_cnt;        // input bit position
   logic [SFE_BYTE_W-2:0]   rx_shift;       // first seven bits of a byte
   logic                    byte_done;      // eighth bit sampled now
   logic [SFE_HDR_W-1:0]    hdr_cnt;        // header bytes seen
   logic [SFE_PAGE_W-1:0]   data_cnt;       // data bytes seen
   logic [SFE_BYTE_W-1:0]   tx_shift;       // output bits not yet driven
   logic [SFE_CNT_W-1:0]    out_rem;        // falls left in output byte
   logic                    load_now;       // take a new output byte
   logic                    drive_ok;       // output may be enabled

   sfe_stream_if #(.WIDTH(SFE_RX_W)) rx_in ();    // shifter into fifo
   sfe_stream_if #(.WIDTH(SFE_RX_W)) rx_out ();   // fifo into output stage

   // -------------------------------------------------------------
   // pin edges
   // -------------------------------------------------------------
   // reset history low so a select held low through reset is no start
   sfe_edge #(.RESET_LEVEL(SFE_SEL_RST)) u_sel_edge (
      .clk     (clk),
      .resetn  (resetn),
      .level   (select_n),
      .level_q (sel_q),
      .rise    (sel_rise),
      .fall    (sel_fall)
   );

   sfe_edge #(.RESET_LEVEL(SFE_SCK_RST)) u_sck_edge (
      .clk     (clk),
      .resetn  (resetn),
      .level   (sck),
      .level_q (sck_q),
      .rise    (sck_rise),
      .fall    (sck_fall)
   );

   // clock edges count only inside a frame and outside a pause
   assign live    = (state == SFE_ST_SELECTED) & pause_n;
   // the edge preceding the first sampled rise is a fall in mode 3;
   // nothing is loaded then because no output byte is offered yet
   assign in_rise = sck_rise & live & ~sel_rise;
   assign in_fall = sck_fall & live & ~sel_rise;
   assign drive_ok = (state == SFE_ST_SELECTED) & ~sel_rise & pause_n;

   // -------------------------------------------------------------
   // frame state
   // -------------------------------------------------------------
   // a rise while a program or erase runs parks in finishing
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= SFE_ST_STANDBY;
      end else begin
         case (state)
            SFE_ST_STANDBY: begin
               if (sel_fall) begin
                  state <= SFE_ST_SELECTED;
               end
            end
            SFE_ST_SELECTED: begin
               if (sel_rise) begin
                  state <= op_busy ? SFE_ST_FINISHING : SFE_ST_STANDBY;
               end
            end
            SFE_ST_FINISHING: begin
               // host may reselect to poll while the cycle still runs
               if (sel_fall) begin
                  state <= SFE_ST_SELECTED;
               end else if (!op_busy) begin
                  state <= SFE_ST_STANDBY;
               end
            end
            default: begin
               state <= SFE_ST_STANDBY;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // input shifter
   // -------------------------------------------------------------
   // in dual output the input pin is ours, so no bits are taken
   assign byte_done = in_rise & (out_state != SFE_OUT_DUAL) & (bit_cnt == SFE_LAST_BIT);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt  <= SFE_BIT_ZERO;
         rx_shift <= '0;
      end else if (sel_fall) begin
         bit_cnt  <= SFE_BIT_ZERO;
         rx_shift <= '0;
      end else if (in_rise && out_state != SFE_OUT_DUAL) begin
         bit_cnt  <= bit_cnt + 1'b1;
         rx_shift <= {rx_shift[SFE_BYTE_W-3:0], dual_lane0_in};
      end
   end

   // whole byte: seven stored bits then the one on the pin now
   assign rx_in.valid = byte_done;
   assign rx_in.data  = {(hdr_cnt == '0), rx_shift, dual_lane0_in};

   // -------------------------------------------------------------
   // byte accounting
   // -------------------------------------------------------------
   // header first, then data bytes counted up to a page
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hdr_cnt  <= '0;
         data_cnt <= '0;
      end else if (sel_fall) begin
         hdr_cnt  <= '0;
         data_cnt <= '0;
      end else if (byte_done) begin
         if (hdr_cnt != HDR_BYTES) begin
            hdr_cnt <= hdr_cnt + 1'b1;
         end else if (data_cnt != PAGE_BYTES) begin
            data_cnt <= data_cnt + 1'b1;
         end
      end
   end

   // a full page is flagged; later bytes still pass for the array to wrap
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         page_full <= 1'b0;
      end else begin
         page_full <= (data_cnt == PAGE_BYTES);
      end
   end

   // -------------------------------------------------------------
   // receive buffer and output stage
   // -------------------------------------------------------------
   sfe_fifo #(.WIDTH(SFE_RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk    (clk),
      .resetn (resetn),
      .wr     (rx_in),
      .rd     (rx_out)
   );

   // register stage keeps the user outputs straight from flops
   assign rx_out.ready = ~rx_valid | rx_ready;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_valid <= 1'b0;
         rx_first <= 1'b0;
         rx_data  <= '0;
      end else if (rx_out.valid && rx_out.ready) begin
         rx_valid <= 1'b1;
         rx_first <= rx_out.data[SFE_RX_W-1];
         rx_data  <= rx_out.data[SFE_BYTE_W-1:0];
      end else if (rx_ready) begin
         rx_valid <= 1'b0;
      end
   end

   // the serial host cannot be stalled, so a full buffer loses the byte;
   // the loss is flagged until the next select fall
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_overrun <= 1'b0;
      end else if (byte_done && !rx_in.ready) begin
         rx_overrun <= 1'b1;
      end else if (sel_fall) begin
         rx_overrun <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // output serialiser
   // -------------------------------------------------------------
   // a new byte starts only on an input byte boundary or right after
   // the previous output byte
   assign load_now = in_fall & (out_rem == SFE_BIT_ZERO) & tx_valid &
                     ((out_state != SFE_OUT_IDLE) | (bit_cnt == SFE_BIT_ZERO));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_state      <= SFE_OUT_IDLE;
         tx_shift       <= '0;
         out_rem        <= SFE_BIT_ZERO;
         dual_lane1_out <= 1'b0;
         dual_lane0_out <= 1'b0;
      end else if (sel_fall) begin
         out_state <= SFE_OUT_IDLE;
         out_rem   <= SFE_BIT_ZERO;
      end else if (load_now) begin
         dual_lane1_out <= tx_data[SFE_BYTE_W-1];
         if (dual_read) begin
            out_state      <= SFE_OUT_DUAL;
            dual_lane0_out <= tx_data[SFE_BYTE_W-2];
            tx_shift       <= {tx_data[SFE_BYTE_W-3:0], 2'b00};
            out_rem        <= SFE_DUAL_REM;
         end else begin
            out_state <= SFE_OUT_SINGLE;
            tx_shift  <= {tx_data[SFE_BYTE_W-2:0], 1'b0};
            out_rem   <= SFE_SINGLE_REM;
         end
      end else if (in_fall && out_rem != SFE_BIT_ZERO) begin
         dual_lane1_out <= tx_shift[SFE_BYTE_W-1];
         out_rem        <= out_rem - 1'b1;
         if (out_state == SFE_OUT_DUAL) begin
            dual_lane0_out <= tx_shift[SFE_BYTE_W-2];
            tx_shift       <= {tx_shift[SFE_BYTE_W-3:0], 2'b00};
         end else begin
            tx_shift <= {tx_shift[SFE_BYTE_W-2:0], 1'b0};
         end
      end
   end

   // byte taken: one-cycle acknowledge, user then offers the next
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_ack <= 1'b0;
      end else begin
         tx_ack <= load_now;
      end
   end

   // a byte boundary with no byte offered repeats the last level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_underrun <= 1'b0;
      end else if (in_fall && out_rem == SFE_BIT_ZERO && out_state != SFE_OUT_IDLE && !tx_valid) begin
         tx_underrun <= 1'b1;
      end else if (sel_fall) begin
         tx_underrun <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // output enables
   // -------------------------------------------------------------
   // released whenever deselected or paused; lane0 only in dual
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dual_lane1_oe <= 1'b0;
         dual_lane0_oe <= 1'b0;
      end else begin
         dual_lane1_oe <= drive_ok & ((out_state != SFE_OUT_IDLE) | load_now);
         dual_lane0_oe <= drive_ok & ((out_state == SFE_OUT_DUAL) |
                                      (load_now & dual_read));
      end
   end

   // -------------------------------------------------------------
   // frame status
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frame_active <= 1'b0;
         frame_end    <= 1'b0;
         standby      <= 1'b1;
      end else begin
         frame_active <= (state == SFE_ST_SELECTED) & ~sel_rise;
         frame_end    <= (state == SFE_ST_SELECTED) & sel_rise;
         standby      <= (state == SFE_ST_STANDBY) & ~sel_fall;
      end
   end

endmodule

// *** verification/sfe_chk.sv ***
`timescale 1ns/1ps
// ---------------------------------------------
// pin timing checks on the front end top ports
// ---------------------------------------------
module sfe_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic select_n,
   input wire logic sck,
   input wire logic pause_n,
   input wire logic op_busy,
   input wire logic dual_lane0_oe,
   input wire logic dual_lane1_oe,
   input wire logic dual_lane1_out,
   input wire logic tx_ack,
   input wire logic frame_active,
   input wire logic frame_end,
   input wire logic standby,
   input wire logic page_full,
   input wire logic rx_overrun
);
   // one domain, so one clock and one reset for all
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_desel_release: assert property (select_n |=> !dual_lane1_oe && !dual_lane0_oe)
      else $error("output enabled while deselected");
   a_pause_release: assert property (!pause_n |=> !dual_lane1_oe && !dual_lane0_oe)
      else $error("output enabled during pause");
   a_frame_start: assert property ($fell(select_n) |=> ##1 (frame_active && !standby))
      else $error("select fall did not open a frame");
   a_frame_stop: assert property ($rose(select_n) && frame_active |=> frame_end && !frame_active)
      else $error("select rise did not close the frame");
   a_end_pulse: assert property (frame_end |=> !frame_end)
      else $error("frame end longer than one cycle");
   // a change with the clock high means a launch on the wrong edge
   a_launch_on_fall: assert property (dual_lane1_oe && $past(dual_lane1_oe) && $changed(dual_lane1_out)
      |-> !$past(sck))
      else $error("serial output changed after a rising clock");
   a_dual_pair: assert property (dual_lane0_oe |-> dual_lane1_oe)
      else $error("lane0 driven without lane1");
   a_ack_launch: assert property (tx_ack |-> dual_lane1_oe ##1 !tx_ack)
      else $error("byte taken without driving output");
   a_busy_active: assert property (op_busy |=> !standby)
      else $error("standby during self-timed cycle");
   a_idle_standby: assert property (select_n && !op_busy ##1 select_n |=> standby)
      else $error("no standby while idle");

   c_dual: cover property (dual_lane0_oe);
   c_page: cover property (page_full);
   c_over: cover property (rx_overrun);
   c_busy_end: cover property (frame_end && op_busy);
endmodule

bind sfe_front_end sfe_chk u_chk (.clk(clk), .resetn(resetn), .select_n(select_n), .sck(sck), .pause_n(pause_n),
   .op_busy(op_busy), .dual_lane0_oe(dual_lane0_oe), .dual_lane1_oe(dual_lane1_oe),
   .dual_lane1_out(dual_lane1_out), .tx_ack(tx_ack), .frame_active(frame_active), .frame_end(frame_end),
   .standby(standby), .page_full(page_full), .rx_overrun(rx_overrun));

// *** verification/sfe_host.sv ***
`timescale 1ns/1ps
// ---------------------------------------------
// spi host model, each clock level held 4 cycles
// ---------------------------------------------
module sfe_host (
   input  wire logic clk,
   input  wire logic pin0,
   input  wire logic pin1,
   output logic      select_n,
   output logic      sck,
   output logic      si,
   output logic      pause_n
);
   logic       mode3 = 1'b0;  // clock idles high when set
   logic [7:0] got;           // bits seen on the output lanes
   initial begin
      select_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      pause_n = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge clk);
   endtask
   // idle level first, then the select edge
   task automatic sel(input logic s);
      sck <= mode3;
      hw(4);
      select_n <= s;
      hw(4);
   endtask
   // one bit: launch on fall, sample lanes just before the rise
   task automatic bt(input logic b, input logic dual);
      sck <= 1'b0;
      si <= b;
      hw(4);
      got = dual ? {got[5:0], pin1, pin0} : {got[6:0], pin1};
      sck <= 1'b1;
      hw(4);
   endtask
   // msb first, two bits a clock in dual mode
   task automatic xb(input logic [7:0] d, input logic dual);
      for (int i = 0; i < (dual ? 4 : 8); i++) begin
         bt(d[7-i], dual);
      end
   endtask
   // pause changes only with select low and clock low
   task automatic hold(input logic p);
      sck <= 1'b0;
      hw(4);
      pause_n <= p;
      hw(4);
   endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import sfe_pkg::*;
   logic       clk = 1'b0;
   logic       resetn, rx_ready, tx_valid, dual_read, op_busy;
   logic [7:0] tx_data, rx_data;
   logic       l0_out, l0_oe, l1_out, l1_oe, rx_first, rx_valid, tx_ack;
   logic       frame_active, frame_end, standby, page_full, rx_overrun, tx_underrun;
   logic       select_n, sck, si, pause_n;
   logic       held1 = 1'b0;  // last lane1 level, inverted when released
   logic [8:0] rxq[$];        // received bytes with first flag
   int         fails = 0;
   int         checked = 0;
   int         cycles = 0;
   wire        pin0 = l0_oe ? l0_out : si;
   wire        pin1 = l1_oe ? l1_out : ~held1;

   always #4 clk = ~clk;
   // ---------------------------------------------
   // user side: byte sink, byte source, watchdog
   // ---------------------------------------------
   always @(posedge clk) begin
      if (l1_oe) held1 <= l1_out;
      if (rx_valid && rx_ready) rxq.push_back({rx_first, rx_data});
      if (tx_ack) tx_valid <= 1'b0;
      cycles++;
      if (cycles == 60000) begin
         fails++;
         test_done();
      end
   end

   sfe_host u_host (.clk(clk), .pin0(pin0), .pin1(pin1), .select_n(select_n), .sck(sck), .si(si),
      .pause_n(pause_n));
   sfe_front_end u_dut (.clk(clk), .resetn(resetn), .select_n(select_n), .sck(sck), .pause_n(pause_n),
      .dual_lane0_in(pin0), .dual_lane0_out(l0_out), .dual_lane0_oe(l0_oe), .dual_lane1_out(l1_out),
      .dual_lane1_oe(l1_oe), .rx_data(rx_data), .rx_first(rx_first), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ack(tx_ack), .dual_read(dual_read),
      .op_busy(op_busy), .frame_active(frame_active), .frame_end(frame_end), .standby(standby),
      .page_full(page_full), .rx_overrun(rx_overrun), .tx_underrun(tx_underrun));

   task automatic test_done();
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hw(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bytes b, b+1, ... in one go
   task automatic sendn(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) u_host.xb(b + 8'(i), 1'b0);
   endtask
   // header plus one data byte, in clock mode 0 or 3
   task automatic t_frame(input logic m);
      u_host.mode3 = m;
      rxq.delete();
      u_host.sel(1'b0);
      sendn(8'hA1, 5);
      u_host.sel(1'b1);
      hw(8);
      chk(16'(rxq.size()), 16'h5);
      for (int i = 0; i < 5; i++) chk(16'(rxq[i]), {7'h0, i == 0, 8'hA1 + 8'(i)});
      chk(16'(standby), 16'h1);
   endtask
   // clock and data while deselected go nowhere
   task automatic t_idle();
      u_host.mode3 = 1'b0;
      rxq.delete();
      sendn(8'h5A, 2);
      hw(8);
      chk(16'(rxq.size()), 16'h0);
      chk(16'(frame_active), 16'h0);
   endtask
   // opcode in, then one byte out on one or two lanes
   task automatic t_read(input logic dual, input logic [7:0] d);
      u_host.sel(1'b0);
      u_host.xb(8'h3B, 1'b0);
      tx_data <= d;
      tx_valid <= 1'b1;
      dual_read <= dual;
      u_host.xb(8'h00, dual);
      chk(16'(u_host.got), 16'(d));
      u_host.sel(1'b1);
      chk(16'(tx_underrun), 16'h1);
      chk(16'(tx_valid), 16'h0);
      dual_read <= 1'b0;
   endtask
   // clock pulses during a pause must not count
   task automatic t_pause();
      logic [7:0] pat;
      pat = 8'hA5;
      rxq.delete();
      u_host.sel(1'b0);
      for (int i = 7; i > 3; i--) u_host.bt(pat[i], 1'b0);
      u_host.hold(1'b0);
      for (int i = 0; i < 4; i++) u_host.bt(1'b1, 1'b0);
      u_host.hold(1'b1);
      for (int i = 3; i >= 0; i--) u_host.bt(pat[i], 1'b0);
      u_host.sel(1'b1);
      hw(8);
      chk(16'(rxq.size()), 16'h1);
      chk(16'(rxq[0]), 16'h1A5);
   endtask
   // standby waits for the self-timed cycle
   task automatic t_busy();
      u_host.sel(1'b0);
      sendn(8'h11, 1);
      op_busy <= 1'b1;
      u_host.sel(1'b1);
      hw(8);
      chk(16'(standby), 16'h0);
      u_host.sel(1'b0);
      chk(16'(frame_active), 16'h1);
      u_host.sel(1'b1);
      chk(16'(standby), 16'h0);
      op_busy <= 1'b0;
      hw(3);
      chk(16'(standby), 16'h1);
   endtask
   // user stalls: buffer fills, overflows, then drains dry
   task automatic t_fill();
      rx_ready <= 1'b0;
      rxq.delete();
      u_host.sel(1'b0);
      sendn(8'h20, 8);
      u_host.sel(1'b1);
      chk(16'(rx_overrun), 16'h1);
      rx_ready <= 1'b1;
      hw(16);
      chk(16'(rxq[0]), 16'h120);
      chk(16'(rxq.size()), 16'(SFE_FIFO_DEPTH + 1));
      chk(16'(rxq[SFE_FIFO_DEPTH]), 16'h024);
      chk(16'(rx_valid), 16'h0);
   endtask
   // page flag exactly at the 256th data byte
   task automatic t_page();
      rxq.delete();
      u_host.sel(1'b0);
      sendn(8'h00, 259);
      chk(16'(page_full), 16'h0);
      sendn(8'h03, 1);
      chk(16'(page_full), 16'h1);
      u_host.sel(1'b1);
      hw(8);
      chk(16'(rxq.size()), 16'd260);
   endtask

   initial begin
      resetn = 1'b0;
      rx_ready = 1'b1;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      dual_read = 1'b0;
      op_busy = 1'b0;
      hw(2);
      resetn <= 1'b1;
      hw(2);
      t_frame(1'b0);
      t_frame(1'b1);
      t_idle();
      t_read(1'b0, 8'hC6);
      t_read(1'b1, 8'h93);
      t_pause();
      t_busy();
      t_fill();
      t_page();
      test_done();
   end
endmodule
